/* File: hdl/xosc_ctrl.sv */
// Behaviour
// - enable: request, or enable with stop allowance
// - enable low means off, clocks static
// - enable rise with crystal select enters startup
// - count 4096 raw cycles, then forward
// - stable when enabled, crystal, count done
// - output gated until count completes
// - external select forwards pin clock, resampled on ref_clk, without a count
// - range and gain choose oscillator mode
// - done flag set after startup completes
// - select: 0 external, 1 crystal
// - control byte layout, reserved bits zero
`timescale 1ns/1ps
`default_nettype none
module xosc_ctrl
  import xosc_pkg::*;
#(
  parameter int CYCLES = STARTUP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic raw_crystal_clock,
  input wire logic ext_clock_input_pin,
  input wire logic sw_osc_enable,
  input wire logic keep_in_stop,
  input wire logic output_source_select,
  input wire logic range_select,
  input wire logic high_gain_select,
  input wire logic stop_mode,
  input wire logic clockgen_osc_request,
  output logic osc_output_clock,
  output logic startup_done_flag,
  output logic [7:0] osc_control_reg,
  output logic effective_enable,
  output xosc_state_type osc_state,
  output logic pins_coupled,
  output logic amp_enable,
  output logic amp_high_range,
  output logic amp_high_gain
);

  typedef struct packed {
    logic xtl_s1;
    logic xtl_s2;
    logic ext_s1;
    logic ext_s2;
    logic done_s1;
    logic done_s2;
    logic armed;
    logic osc_req;
    logic rst_req;
    logic cnt_req;
    xosc_state_type state;
    xosc_src_type src;
    logic out_clk;
    logic done_flag;
    logic eff_en;
    logic coupled;
    logic amp_en;
    logic high_range;
    logic high_gain;
    logic [7:0] ctl;
  } xosc_main_type;

  xosc_main_type st_q, st_d;
  logic en;
  logic done_ok;
  xosc_state_type want_state;
  xosc_src_type want_src;

  xosc_link_if lnk ();

  ////////////////////////////////////////////////////////////////////////
  // crystal domain counter

  xosc_startup_counter #(
    .CYCLES(CYCLES)
  ) u_counter (
    .raw_crystal_clock(raw_crystal_clock),
    .lnk(lnk)
  );

  // count request only after the counter has shown done low, so a frozen done is never reused
  assign lnk.osc_req = st_q.cnt_req;
  assign lnk.rst_req = st_q.rst_req;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // sampled level of a source; none reads low
  function automatic logic level_of(input xosc_src_type s, input logic xtl, input logic ext);
    logic lvl;
    lvl = 1'b0;
    if (s == src_crystal_drive_pin) begin
      lvl = xtl;
    end else if (s == src_ext) begin
      lvl = ext;
    end
    return lvl;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    // request overrides the stop gating entirely
    en = clockgen_osc_request || (sw_osc_enable && (!stop_mode || keep_in_stop));
    // stale done from a previous run is ignored until seen low once
    done_ok = st_q.done_s2 && st_q.armed;
    if (!en) begin
      want_state = st_off;
    end else if (output_source_select == SRC_EXTERNAL) begin
      want_state = st_external;
    end else if (done_ok) begin
      want_state = st_stable;
    end else begin
      want_state = st_startup;
    end
    unique case (want_state)
      st_stable: want_src = src_crystal_drive_pin;
      st_external: want_src = src_ext;
      default: want_src = src_none;
    endcase
    st_d.xtl_s1 = raw_crystal_clock;
    st_d.xtl_s2 = st_q.xtl_s1;
    st_d.ext_s1 = ext_clock_input_pin;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.done_s1 = lnk.cnt_done;
    st_d.done_s2 = st_q.done_s1;
    st_d.rst_req = rst;
    st_d.osc_req = en && (output_source_select == SRC_CRYSTAL);
    if (!st_q.osc_req) begin
      st_d.armed = 1'b0;
    end else if (!st_q.done_s2) begin
      st_d.armed = 1'b1;
    end
    // raw clock stops when off, so the counter can only clear once it runs again with request low
    st_d.cnt_req = st_d.osc_req && st_d.armed;
    st_d.state = want_state;
    // change source only while both old output and new source are low
    if (!st_q.out_clk && !level_of(want_src, st_q.xtl_s2, st_q.ext_s2)) begin
      st_d.src = want_src;
    end
    st_d.out_clk = level_of(st_d.src, st_q.xtl_s2, st_q.ext_s2);
    st_d.done_flag = (want_state == st_stable);
    st_d.eff_en = en;
    st_d.coupled = en;
    st_d.amp_en = st_d.osc_req;
    st_d.high_range = st_d.osc_req && (range_select == RANGE_HIGH);
    st_d.high_gain = st_d.osc_req && (high_gain_select == GAIN_HIGH);
    st_d.ctl = CR_RESET;
    st_d.ctl[CR_ENABLE_BIT] = sw_osc_enable;
    st_d.ctl[CR_KEEP_STOP_BIT] = keep_in_stop;
    st_d.ctl[CR_SRC_SEL_BIT] = output_source_select;
    st_d.ctl[CR_RANGE_BIT] = range_select;
    st_d.ctl[CR_HIGH_GAIN_BIT] = high_gain_select;
    st_d.ctl[CR_DONE_BIT] = st_d.done_flag;
  end

  // system reset puts everything off; rst_req carries it across
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.rst_req <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign osc_output_clock = st_q.out_clk;
  assign startup_done_flag = st_q.done_flag;
  assign osc_control_reg = st_q.ctl;
  assign effective_enable = st_q.eff_en;
  assign osc_state = st_q.state;
  assign pins_coupled = st_q.coupled;
  assign amp_enable = st_q.amp_en;
  assign amp_high_range = st_q.high_range;
  assign amp_high_gain = st_q.high_gain;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_enable_decode: assert property (
    ##1 effective_enable == $past(clockgen_osc_request || (sw_osc_enable && (!stop_mode || keep_in_stop))))
    else $error("effective enable decode wrong");
  a_off_when_low: assert property (!effective_enable |-> osc_state == st_off && !pins_coupled)
    else $error("not off while enable low");
  a_external_state: assert property (
    effective_enable && !$past(output_source_select) |-> osc_state == st_external)
    else $error("external select not honoured");
  a_stable_needs_done: assert property (
    osc_state == st_stable |-> $past(st_q.done_s2) && $past(st_q.armed) && $past(output_source_select))
    else $error("stable without completed count");
  a_gate_in_startup: assert property (osc_state == st_startup |-> st_q.src != src_crystal_drive_pin)
    else $error("crystal clock passed during startup");
  a_flag_tracks: assert property (startup_done_flag == (osc_state == st_stable))
    else $error("done flag disagrees with state");
  a_mode_gated: assert property ((amp_high_range || amp_high_gain) |-> amp_enable)
    else $error("mode bits active outside oscillator mode");
  a_reg_layout: assert property (
    ##1 osc_control_reg[CR_RSVD_HI_BIT] == 1'b0 && osc_control_reg[CR_RSVD_LO_BIT] == 1'b0
    && osc_control_reg[CR_ENABLE_BIT] == $past(sw_osc_enable))
    else $error("control byte layout wrong");
  a_switch_clean: assert property ($changed(st_q.src) |-> !$past(osc_output_clock))
    else $error("source switched while output high");
  a_restart_after_clear: assert property ($rose(st_q.cnt_req) |-> !$past(st_q.done_s2))
    else $error("count requested before stale done cleared");

  c_reach_stable: cover property (osc_state == st_startup ##[1:1000] osc_state == st_stable);
  c_reach_external: cover property (osc_state == st_off ##1 osc_state == st_external);
  c_stable_to_off: cover property (osc_state == st_stable ##1 osc_state == st_off);

endmodule
`default_nettype wire

/* File: hdl/xosc_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// levels passing between the system domain and the raw crystal domain
interface xosc_link_if;
  logic osc_req;
  logic rst_req;
  logic cnt_done;
  modport ref_side (output osc_req, output rst_req, input cnt_done);
  modport crystal_drive_pin_side (input osc_req, input rst_req, output cnt_done);
endinterface
`default_nettype wire

/* File: hdl/xosc_pkg.sv */
`default_nettype none
package xosc_pkg;

  // control register field positions
  localparam int CR_ENABLE_BIT = 7;
  localparam int CR_RSVD_HI_BIT = 6;
  localparam int CR_KEEP_STOP_BIT = 5;
  localparam int CR_SRC_SEL_BIT = 4;
  localparam int CR_RSVD_LO_BIT = 3;
  localparam int CR_RANGE_BIT = 2;
  localparam int CR_HIGH_GAIN_BIT = 1;
  localparam int CR_DONE_BIT = 0;
  localparam logic [7:0] CR_RESET = 8'h00;

  // source select and mode encodings
  localparam logic SRC_EXTERNAL = 1'b0;
  localparam logic SRC_CRYSTAL = 1'b1;
  localparam logic RANGE_LOW = 1'b0;
  localparam logic RANGE_HIGH = 1'b1;
  localparam logic GAIN_LOW_POWER = 1'b0;
  localparam logic GAIN_HIGH = 1'b1;

  // raw crystal cycles seen before the output is released
  localparam int STARTUP_CYCLES = 4096;

  typedef enum logic [1:0] {
    st_off,
    st_startup,
    st_stable,
    st_external
  } xosc_state_type;

  typedef enum logic [1:0] {
    src_none,
    src_crystal_drive_pin,
    src_ext
  } xosc_src_type;

endpackage
`default_nettype wire

/* File: hdl/xosc_startup_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module xosc_startup_counter
  import xosc_pkg::*;
#(
  parameter int CYCLES = STARTUP_CYCLES
) (
  input wire logic raw_crystal_clock,
  xosc_link_if.crystal_drive_pin_side lnk
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic rst_s1;
    logic rst_s2;
    logic [CW-1:0] cnt;
    logic done;
  } xosc_cnt_type;

  xosc_cnt_type st_q, st_d;

  // count raw edges while oscillator mode is requested; clear otherwise
  always_comb begin
    st_d = st_q;
    st_d.req_s1 = lnk.osc_req;
    st_d.req_s2 = st_q.req_s1;
    st_d.rst_s1 = lnk.rst_req;
    st_d.rst_s2 = st_q.rst_s1;
    if (st_q.rst_s2 || !st_q.req_s2) begin
      st_d.cnt = '0;
      st_d.done = 1'b0;
    end else if (!st_q.done) begin
      st_d.cnt = st_q.cnt + CW'(1);
      st_d.done = (st_q.cnt == LAST);
    end
  end

  // no reset here: the system reset arrives as a synchronised level
  always_ff @(posedge raw_crystal_clock) begin
    st_q <= st_d;
  end

  assign lnk.cnt_done = st_q.done;

  a_done_after_count: assert property (@(posedge raw_crystal_clock) disable iff (st_q.rst_s2)
    $rose(st_q.done) |-> $past(st_q.cnt) == LAST)
    else $error("startup count ended at wrong cycle");
  a_count_cleared: assert property (@(posedge raw_crystal_clock) disable iff (st_q.rst_s2)
    !st_q.req_s2 |=> st_q.cnt == '0 && !st_q.done)
    else $error("counter not cleared when mode dropped");

endmodule
`default_nettype wire

/* File: tb/xosc_crystal_drive_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// crystal model: the raw clock only runs while run is high (the amplifier is powered, or reset is held)
module xosc_crystal_drive_pin_model #(
  parameter realtime HALF = 15.0
) (
  input wire logic run,
  output logic raw_crystal_clock
);
  // stands still at low when unpowered, so no stale edge reaches the counter
  initial begin
    raw_crystal_clock = 1'b0;
    #3.7;
    forever begin
      #(HALF);
      if (run) raw_crystal_clock = ~raw_crystal_clock;
      else raw_crystal_clock = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/xosc_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module xosc_ctrl_tb_top;
  import xosc_pkg::*;
  localparam int CYC = 8;
  logic ref_clk = 1'b0, rst = 1'b1, en = 1'b0, keep = 1'b0, sel = 1'b0, stop = 1'b0, req = 1'b0;
  logic rng = 1'b0, gn = 1'b0, raw, out_clk, done, eff, pins, amp_en, amp_rng, amp_gn;
  logic [2:0] ext_div = 3'h0;
  logic [7:0] ctl;
  xosc_state_type osc_state;
  int error_cnt = 0, num_checks = 0, raw_cnt = 0, k;
  logic [4:0] rows [5] = '{5'h10, 5'h08, 5'h0d, 5'h09, 5'h06};
  logic [4:0] want = 5'b11100;

  always #5 ref_clk = ~ref_clk;
  // slow pin clock, far below the sampling rate so the 2ff sampler follows it
  always @(posedge ref_clk) ext_div <= ext_div + 3'h1;
  always @(posedge raw) raw_cnt++;

  xosc_crystal_drive_pin_model u_xosc_crystal_drive_pin_model (.run(amp_en | rst), .raw_crystal_clock(raw));
  xosc_ctrl #(.CYCLES(CYC)) u_xosc_ctrl (.ref_clk(ref_clk), .rst(rst), .raw_crystal_clock(raw),
    .ext_clock_input_pin(ext_div[2]), .sw_osc_enable(en), .keep_in_stop(keep),
    .output_source_select(sel), .range_select(rng), .high_gain_select(gn), .stop_mode(stop),
    .clockgen_osc_request(req), .osc_output_clock(out_clk), .startup_done_flag(done),
    .osc_control_reg(ctl), .effective_enable(eff), .osc_state(osc_state), .pins_coupled(pins),
    .amp_enable(amp_en), .amp_high_range(amp_rng), .amp_high_gain(amp_gn));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // {req,en,keep,sel,stop}, then let the one-cycle answer settle
  task automatic drive(input logic [4:0] v);
    @(posedge ref_clk);
    {req, en, keep, sel, stop} <= v;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // counts output changes; a frozen output must show no more than two
  task automatic toggles(input logic running);
    logic last;
    int n;
    last = out_clk;
    n = 0;
    repeat (60) begin
      @(posedge ref_clk);
      #1;
      if (out_clk !== last) n++;
      last = out_clk;
    end
    chk({7'h0, n > 2}, {7'h0, running});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // five rows of the enable decode; sel is high only in the last, with enable low, so no count starts
  task automatic enable_table();
    rng <= 1'b1;
    gn <= 1'b1;
    for (k = 0; k < 5; k++) begin
      drive(rows[k]);
      chk({6'h0, eff, pins}, {6'h0, want[4 - k], want[4 - k]});
      chk(ctl, {rows[k][3], 1'b0, rows[k][2], rows[k][1], 1'b0, 2'b11, 1'b0});
      chk({6'h0, osc_state}, {6'h0, want[4 - k] ? st_external : st_off});
    end
  endtask

  // full startup; output must stay frozen until the raw count is done
  task automatic run_startup(input logic r, input logic g);
    logic last;
    int i, n;
    @(posedge ref_clk);
    rng <= r;
    gn <= g;
    drive(5'h0a);
    chk({6'h0, osc_state}, {6'h0, st_startup});
    chk({6'h0, done, ctl[0]}, 8'h00);
    chk({5'h0, amp_en, amp_rng, amp_gn}, {5'h0, 1'b1, r, g});
    raw_cnt = 0;
    last = out_clk;
    n = 0;
    for (i = 0; i < 400 && osc_state !== st_stable; i++) begin
      @(posedge ref_clk);
      #1;
      if (out_clk !== last) n++;
    end
    chk(8'(n), 8'h00);
    chk({7'h0, raw_cnt >= CYC}, 8'h01);
    chk({5'h0, osc_state, done}, {5'h0, st_stable, 1'b1});
    chk({7'h0, ctl[0]}, 8'h01);
    chk({7'h0, i < 400}, 8'h01);
    toggles(1'b1);
  endtask

  // pin clock path, then back to crystal repeats the whole count
  task automatic external_then_back();
    drive(5'h08);
    chk({5'h0, osc_state, done}, {5'h0, st_external, 1'b0});
    chk({7'h0, amp_en}, 8'h00);
    toggles(1'b1);
    run_startup(1'b1, 1'b1);
  endtask

  // off freezes the output and decouples the pins
  task automatic go_off();
    drive(5'h00);
    chk({5'h0, osc_state, pins}, {5'h0, st_off, 1'b0});
    chk({7'h0, done}, 8'h00);
    toggles(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    enable_table();
    for (k = 0; k < 4; k++) begin
      go_off();
      run_startup(k[1], k[0]);
    end
    external_then_back();
    go_off();
    end_of_test();
  end
endmodule
`default_nettype wire
